// ==== rxq_pkg.sv ====
// Constants, types and offsets shared by the receive queue enable control.
// Functional notes
// [R1] Software invalidates unused receive address entries and programs used ones first.
// [R2] Multicast and vlan tables reset to zero; a set bit permits a match.
// [R3] Software enables filter ECC reporting only after filter memories are initialised.
// [R4] Software sets both NFS detection disable bits to one.
// [R5] For jumbo frames software sets jumbo enable and the maximum frame size.
// [R6] Packets steered to a queue that is not enabled are dropped.
// [R7] Software waits for enable to read one before moving the tail.
// [R8] Tail written to ring length minus one starts descriptor fetching.
// [R9] Software sets global receive enable last.
// [R10] Per-queue long packet limit bounds accepted packet length when enabled.
// [R11] Software drains coalescing contexts for two throttle intervals before disabling.
// [R12] A cleared queue stops fetch and write-back and drops new packets.
// [R13] On disable, the current buffer finishes; later buffers are not written.
// [R14] Enable reads one until all outstanding ring accesses complete.
// [R15] Software waits about 100 us after enable reads zero before freeing memory.
// [R16] Software disables global receive only after all queues are disabled.
// [R17] Software delays re-enabling until no stale packets for the queue remain.
// [R18] Coalescing settings are static while queues are enabled.
// [R19] With ack change completion set, an ack flag change closes the context.
// [R20] Header buffer must exceed packet header; 128 bytes suffices.
// [R21] Per-queue coalescing needs its enable, descriptors, format, header recognition, 2 KB buffers.
// [R22] Interrupt moderation interval must exceed the coalescing completion delay.
// [R23] Enable reads one only once the queue accepts tail-triggered fetches.
package rxq_pkg;
  localparam int NQ_DEF = 4;
  localparam int AW = 12;
  localparam int DW = 32;
  localparam int QW = 13;
  localparam int LENW = 14;
  localparam int TBL_DEPTH = 128;
  localparam int TBL_AW = 7;
  // ****************************
  // Register offsets
  // ****************************
  localparam logic [AW-1:0] GCTRL_OFS = 12'h000;
  localparam logic [AW-1:0] FRAME_OFS = 12'h004;
  localparam logic [AW-1:0] STAT_OFS = 12'h008;
  localparam logic [AW-1:0] QBASE_OFS = 12'h100;
  localparam logic [AW-1:0] MCAST_OFS = 12'h800;
  localparam logic [AW-1:0] VLAN_OFS = 12'hC00;
  localparam logic [3:0] QCTRL_SUB = 4'h0;
  localparam logic [3:0] QLEN_SUB = 4'h4;
  localparam logic [3:0] QTAIL_SUB = 4'h8;
  localparam logic [3:0] QHEAD_SUB = 4'hC;
  // ****************************
  // Field positions
  // ****************************
  localparam int G_RXEN = 0;
  localparam int G_MFE = 1;
  localparam int G_VFE = 2;
  localparam int G_ACKC = 3;
  localparam int G_ECC = 4;
  localparam int G_NFSW = 5;
  localparam int G_NFSR = 6;
  localparam int G_JUMBO = 7;
  localparam int GW = 8;
  localparam int Q_EN = 0;
  localparam int Q_LPML_EN = 1;
  localparam int Q_COAL_EN = 2;
  localparam int Q_LIMIT_LSB = 16;
  // ****************************
  // Reset values and timing
  // ****************************
  localparam logic [GW-1:0] GCTRL_RST = 8'h00;
  localparam logic [LENW-1:0] STD_FRAME = 14'h05EE;
  localparam logic [LENW-1:0] LIMIT_RST = 14'h05EE;
  localparam logic [QW-1:0] RING_RST = 13'h0000;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int ARM_TIME_NS = 20;
  localparam int ARM_CYCLES = (ARM_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  typedef enum logic [1:0] {Q_OFF, Q_ARM, Q_ON, Q_DRAIN} qstate_t;
endpackage

// ==== filter_tbl_if.sv ====
// Connection between the control logic and a filter bit table.
`timescale 1ns/1ps
`default_nettype none
interface filter_tbl_if;
  logic                      sw_we;
  logic [rxq_pkg::TBL_AW-1:0] sw_addr;
  logic [rxq_pkg::DW-1:0]     sw_wdata;
  logic [rxq_pkg::DW-1:0]     sw_rdata;
  logic [rxq_pkg::TBL_AW-1:0] lk_addr;
  logic [rxq_pkg::DW-1:0]     lk_rdata;
  modport ctl (output sw_we, sw_addr, sw_wdata, lk_addr, input sw_rdata, lk_rdata);
  modport mem (input sw_we, sw_addr, sw_wdata, lk_addr, output sw_rdata, lk_rdata);
endinterface
`default_nettype wire

// ==== filter_table_mem.sv ====
// Filter bit table, zeroed by reset, with registered read ports.
`timescale 1ns/1ps
`default_nettype none
module filter_table_mem (
  input wire logic clk,
  input wire logic nrst,
  filter_tbl_if.mem t
);
  import rxq_pkg::*;
  logic [DW-1:0] mem_r [TBL_DEPTH];
  logic [DW-1:0] sw_rdata_r;
  logic [DW-1:0] lk_rdata_r;
  genvar i;
  generate
    for (i = 0; i < TBL_DEPTH; i++) begin : g_ent
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          mem_r[i] <= '0; // R2
        end else if (t.sw_we && t.sw_addr == TBL_AW'(i)) begin
          mem_r[i] <= t.sw_wdata;
        end
      end
    end
  endgenerate
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sw_rdata_r <= '0;
      lk_rdata_r <= '0;
    end else begin
      sw_rdata_r <= mem_r[t.sw_addr];
      lk_rdata_r <= mem_r[t.lk_addr];
    end
  end
  assign t.sw_rdata = sw_rdata_r;
  assign t.lk_rdata = lk_rdata_r;
endmodule
`default_nettype wire

// ==== rx_queue_enable_control.sv ====
// Receive queue enable, filtering, drain and coalescing context control.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module rx_queue_enable_control #(
  parameter int NQ  = rxq_pkg::NQ_DEF,
  parameter int QIW = (NQ > 1) ? $clog2(NQ) : 1
) (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic [rxq_pkg::AW-1:0]    reg_addr,
  input  wire logic [rxq_pkg::DW-1:0]    reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic [rxq_pkg::DW-1:0]         reg_rdata,
  input  wire logic                      pkt_valid,
  input  wire logic [QIW-1:0]            pkt_queue,
  input  wire logic [rxq_pkg::LENW-1:0]  pkt_len,
  input  wire logic                      pkt_mcast,
  input  wire logic [11:0]               pkt_hash,
  input  wire logic                      pkt_tagged,
  input  wire logic [11:0]               pkt_vlan,
  input  wire logic                      pkt_ack,
  output logic                           pkt_accept,
  output logic                           pkt_drop,
  output logic [QIW-1:0]                 pkt_out_queue,
  output logic                           ctx_close,
  output logic [NQ-1:0]                  fetch_req,
  input  wire logic [NQ-1:0]             fetch_ack,
  input  wire logic [NQ-1:0]             mem_done,
  output logic [NQ-1:0]                  wb_allow,
  input  wire logic                      dma_buf_req,
  input  wire logic [QIW-1:0]            dma_buf_queue,
  output logic                           dma_buf_grant,
  output logic                           filter_ecc_report_enable,
  output logic                           nfs_write_detect_disable,
  output logic                           nfs_read_detect_disable
);
  import rxq_pkg::*;

  // ****************************
  // Register decode
  // ****************************
  logic [GW-1:0]   gctrl_r;
  logic [LENW-1:0] max_frame_size_r;
  logic [NQ-1:0]   rx_queue_enable_r;
  logic [NQ-1:0]   lpml_en_r;
  logic [NQ-1:0]   coal_en_r;
  logic [NQ-1:0]   en_rd;
  logic [NQ-1:0]   q_on;
  logic [LENW-1:0] limit_r [NQ];
  logic [QW-1:0]   ring_len_r [NQ];
  logic [QW-1:0]   tail_r [NQ];
  logic [QW-1:0]   head_r [NQ];
  logic [NQ-1:0]   ctx_open_r;
  logic [NQ-1:0]   ctx_ack_r;

  wire [QIW-1:0] wq = reg_addr[4 +: QIW];
  wire [3:0] sub = reg_addr[3:0];
  wire qsel = (reg_addr[AW-1:8] == QBASE_OFS[AW-1:8]) && (int'(reg_addr[7:4]) < NQ);
  wire mc_sel = reg_addr[AW-1:9] == MCAST_OFS[AW-1:9];
  wire vl_sel = reg_addr[AW-1:9] == VLAN_OFS[AW-1:9];
  wire g_wr = reg_wr && reg_addr == GCTRL_OFS;
  wire f_wr = reg_wr && reg_addr == FRAME_OFS;

  filter_tbl_if mc_if ();
  filter_tbl_if vl_if ();
  assign mc_if.sw_we = reg_wr && mc_sel;
  assign mc_if.sw_addr = reg_addr[8:2];
  assign mc_if.sw_wdata = reg_wdata;
  assign mc_if.lk_addr = pkt_hash[11:5];
  assign vl_if.sw_we = reg_wr && vl_sel;
  assign vl_if.sw_addr = reg_addr[8:2];
  assign vl_if.sw_wdata = reg_wdata;
  assign vl_if.lk_addr = pkt_vlan[11:5];

  filter_table_mem u_mcast (.clk(clk), .nrst(nrst), .t(mc_if.mem));
  filter_table_mem u_vlan (.clk(clk), .nrst(nrst), .t(vl_if.mem));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gctrl_r <= GCTRL_RST;
      max_frame_size_r <= STD_FRAME;
    end else begin
      if (g_wr) gctrl_r <= reg_wdata[GW-1:0];
      if (f_wr) max_frame_size_r <= reg_wdata[LENW-1:0];
    end
  end
  assign filter_ecc_report_enable = gctrl_r[G_ECC];
  assign nfs_write_detect_disable = gctrl_r[G_NFSW];
  assign nfs_read_detect_disable = gctrl_r[G_NFSR];

  // ****************************
  // Per-queue control
  // ****************************
  wire grant_any = dma_buf_req && q_on[dma_buf_queue];
  assign dma_buf_grant = grant_any; // R13

  genvar q;
  generate
    for (q = 0; q < NQ; q++) begin : g_q
      qstate_t     st_r;
      logic [2:0]  arm_cnt_r;
      logic [7:0]  outst_r;
      wire wr_q = reg_wr && qsel && wq == QIW'(q);
      wire inc_f = fetch_ack[q];
      wire inc_b = grant_any && dma_buf_queue == QIW'(q);
      wire [7:0] outst_nxt = outst_r + 8'(inc_f) + 8'(inc_b) - 8'(mem_done[q]);
      wire [QW-1:0] head_nxt = (head_r[q] == ring_len_r[q] - 13'h0001) ? 13'h0000 : head_r[q] + 13'h0001;

      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          rx_queue_enable_r[q] <= 1'b0;
          lpml_en_r[q] <= 1'b0;
          coal_en_r[q] <= 1'b0;
          limit_r[q] <= LIMIT_RST;
          ring_len_r[q] <= RING_RST;
          tail_r[q] <= RING_RST;
        end else if (wr_q) begin
          if (sub == QCTRL_SUB) begin
            rx_queue_enable_r[q] <= reg_wdata[Q_EN];
            lpml_en_r[q] <= reg_wdata[Q_LPML_EN];
            coal_en_r[q] <= reg_wdata[Q_COAL_EN];
            limit_r[q] <= reg_wdata[Q_LIMIT_LSB +: LENW];
          end
          if (sub == QLEN_SUB) ring_len_r[q] <= reg_wdata[QW-1:0];
          if (sub == QTAIL_SUB) tail_r[q] <= reg_wdata[QW-1:0];
        end
      end

      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          st_r <= Q_OFF;
          arm_cnt_r <= 3'h0;
          outst_r <= 8'h00;
          head_r[q] <= RING_RST;
        end else begin
          outst_r <= outst_nxt;
          if (inc_f) head_r[q] <= head_nxt;
          case (st_r)
            Q_OFF: begin
              arm_cnt_r <= 3'h0;
              head_r[q] <= RING_RST;
              if (rx_queue_enable_r[q]) st_r <= Q_ARM;
            end
            Q_ARM: begin
              arm_cnt_r <= arm_cnt_r + 3'h1;
              if (!rx_queue_enable_r[q]) st_r <= Q_OFF;
              else if (arm_cnt_r == 3'(ARM_CYCLES - 1)) st_r <= Q_ON; // R23
            end
            Q_ON: begin
              if (!rx_queue_enable_r[q]) st_r <= Q_DRAIN;
            end
            Q_DRAIN: begin
              if (outst_nxt == 8'h00) st_r <= Q_OFF; // R14
            end
            default: st_r <= Q_OFF;
          endcase
        end
      end

      assign en_rd[q] = st_r == Q_ON || st_r == Q_DRAIN; // R14
      assign q_on[q] = rx_queue_enable_r[q] && st_r == Q_ON; // R12
      assign fetch_req[q] = q_on[q] && head_r[q] != tail_r[q]; // R8
      assign wb_allow[q] = q_on[q]; // R12

      chk_hold_enable: assert property (@(posedge clk) disable iff (!nrst) // R14
        en_rd[q] && outst_nxt != 8'h00 |=> en_rd[q]) else $error("enable dropped with accesses pending");
      chk_ready_shown: assert property (@(posedge clk) disable iff (!nrst) // R23
        $rose(en_rd[q]) |-> $past(st_r) == Q_ARM && $past(arm_cnt_r) == 3'(ARM_CYCLES - 1))
        else $error("enable shown before queue ready");
      chk_no_fetch_off: assert property (@(posedge clk) disable iff (!nrst) // R12
        wr_q && sub == QCTRL_SUB && !reg_wdata[Q_EN] |=> !fetch_req[q] && !wb_allow[q])
        else $error("fetch on cleared queue");
      chk_fetch_start: assert property (@(posedge clk) disable iff (!nrst) // R8
        wr_q && sub == QTAIL_SUB && q_on[q] && reg_wdata[QW-1:0] != head_r[q] && !inc_f
        |=> fetch_req[q] || !q_on[q]) else $error("tail write did not start fetch");
      cov_drain_done: cover property (@(posedge clk) disable iff (!nrst)
        st_r == Q_DRAIN ##1 st_r == Q_OFF);
    end
  endgenerate

  // ****************************
  // Packet filter pipeline
  // ****************************
  logic            s1_v_r;
  logic [QIW-1:0]  s1_q_r;
  logic [LENW-1:0] s1_len_r;
  logic            s1_mc_r;
  logic [4:0]      s1_hbit_r;
  logic            s1_tag_r;
  logic [4:0]      s1_vbit_r;
  logic            s1_ack_r;
  logic            pkt_accept_r;
  logic            pkt_drop_r;
  logic [QIW-1:0]  pkt_out_queue_r;
  logic            ctx_close_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_v_r <= 1'b0;
      s1_q_r <= '0;
      s1_len_r <= '0;
      s1_mc_r <= 1'b0;
      s1_hbit_r <= 5'h00;
      s1_tag_r <= 1'b0;
      s1_vbit_r <= 5'h00;
      s1_ack_r <= 1'b0;
    end else begin
      s1_v_r <= pkt_valid;
      s1_q_r <= pkt_queue;
      s1_len_r <= pkt_len;
      s1_mc_r <= pkt_mcast;
      s1_hbit_r <= pkt_hash[4:0];
      s1_tag_r <= pkt_tagged;
      s1_vbit_r <= pkt_vlan[4:0];
      s1_ack_r <= pkt_ack;
    end
  end

  wire mc_ok = !s1_mc_r || !gctrl_r[G_MFE] || mc_if.lk_rdata[s1_hbit_r]; // R2
  wire vl_ok = !s1_tag_r || !gctrl_r[G_VFE] || vl_if.lk_rdata[s1_vbit_r]; // R2
  wire [LENW-1:0] frame_lim = gctrl_r[G_JUMBO] ? max_frame_size_r : STD_FRAME;
  wire lim_ok = !lpml_en_r[s1_q_r] || s1_len_r <= limit_r[s1_q_r]; // R10
  wire len_ok = s1_len_r <= frame_lim && lim_ok;
  wire q_ok = q_on[s1_q_r]; // R6
  wire accept = s1_v_r && gctrl_r[G_RXEN] && q_ok && mc_ok && vl_ok && len_ok;
  wire ack_diff = ctx_open_r[s1_q_r] && ctx_ack_r[s1_q_r] != s1_ack_r;
  wire close_now = accept && gctrl_r[G_ACKC] && coal_en_r[s1_q_r] && ack_diff; // R19

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pkt_accept_r <= 1'b0;
      pkt_drop_r <= 1'b0;
      pkt_out_queue_r <= '0;
      ctx_close_r <= 1'b0;
    end else begin
      pkt_accept_r <= accept;
      pkt_drop_r <= s1_v_r && !accept; // R6
      pkt_out_queue_r <= s1_q_r;
      ctx_close_r <= close_now;
    end
  end
  assign pkt_accept = pkt_accept_r;
  assign pkt_drop = pkt_drop_r;
  assign pkt_out_queue = pkt_out_queue_r;
  assign ctx_close = ctx_close_r;

  generate
    for (q = 0; q < NQ; q++) begin : g_ctx
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          ctx_open_r[q] <= 1'b0;
          ctx_ack_r[q] <= 1'b0;
        end else if (!rx_queue_enable_r[q]) begin
          ctx_open_r[q] <= 1'b0;
        end else if (accept && s1_q_r == QIW'(q) && coal_en_r[q]) begin
          ctx_open_r[q] <= 1'b1;
          ctx_ack_r[q] <= s1_ack_r;
        end
      end
    end
  endgenerate

  // ****************************
  // Register read
  // ****************************
  logic [DW-1:0] rdata_r;
  logic          rd_mc_r;
  logic          rd_vl_r;
  wire [DW-1:0] qctrl_rd = {2'b00, limit_r[wq], 13'h0000, coal_en_r[wq], lpml_en_r[wq], en_rd[wq]};
  wire [DW-1:0] qreg_rd = (sub == QCTRL_SUB) ? qctrl_rd :
                          (sub == QLEN_SUB)  ? DW'(ring_len_r[wq]) :
                          (sub == QTAIL_SUB) ? DW'(tail_r[wq]) :
                          (sub == QHEAD_SUB) ? DW'(head_r[wq]) : '0;
  wire [DW-1:0] rd_val = (reg_addr == GCTRL_OFS) ? DW'(gctrl_r) :
                         (reg_addr == FRAME_OFS) ? DW'(max_frame_size_r) :
                         (reg_addr == STAT_OFS)  ? DW'(en_rd) :
                         qsel ? qreg_rd : '0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= '0;
      rd_mc_r <= 1'b0;
      rd_vl_r <= 1'b0;
    end else begin
      rdata_r <= reg_rd ? rd_val : '0;
      rd_mc_r <= reg_rd && mc_sel;
      rd_vl_r <= reg_rd && vl_sel;
    end
  end
  assign reg_rdata = rd_mc_r ? mc_if.sw_rdata : rd_vl_r ? vl_if.sw_rdata : rdata_r;

  // ****************************
  // Checks
  // ****************************
  chk_drop_disabled: assert property (@(posedge clk) disable iff (!nrst) // R6
    s1_v_r && !q_on[s1_q_r] |=> pkt_drop && !pkt_accept) else $error("packet to disabled queue kept");
  chk_long_limit: assert property (@(posedge clk) disable iff (!nrst) // R10
    s1_v_r && lpml_en_r[s1_q_r] && s1_len_r > limit_r[s1_q_r] |=> pkt_drop) else $error("oversize accepted");
  chk_buf_block: assert property (@(posedge clk) disable iff (!nrst) // R13
    reg_wr && qsel && sub == QCTRL_SUB && !reg_wdata[Q_EN] ##1 dma_buf_req && dma_buf_queue == $past(wq)
    |-> !dma_buf_grant) else $error("buffer after disable");
  chk_mcast_filter: assert property (@(posedge clk) disable iff (!nrst) // R2
    s1_v_r && s1_mc_r && gctrl_r[G_MFE] && !mc_if.lk_rdata[s1_hbit_r] |=> !pkt_accept)
    else $error("multicast passed a zero bit");
  chk_ctx_close: assert property (@(posedge clk) disable iff (!nrst) // R19
    ctx_close |-> $past(gctrl_r[G_ACKC]) && $past(ack_diff) && pkt_accept) else $error("bad context close");
  cov_accept: cover property (@(posedge clk) disable iff (!nrst) pkt_accept);
  cov_close: cover property (@(posedge clk) disable iff (!nrst) ctx_close);
endmodule
`default_nettype wire

// ==== ring_mem_model.sv ====
// Behavioural ring memory answering descriptor fetches and buffer writes.
`timescale 1ns/1ps
`default_nettype none
module ring_mem_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       slow,
  input  wire logic [3:0] fetch_req,
  input  wire logic       dma_buf_grant,
  input  wire logic [1:0] dma_buf_queue,
  output logic      [3:0] fetch_ack,
  output logic      [3:0] mem_done
);
  int   pend [4];
  int   tmr  [4];
  logic done;
  // Slow mode keeps accesses outstanding long enough to watch a drain
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fetch_ack <= 4'h0;
      mem_done  <= 4'h0;
      for (int q = 0; q < 4; q++) begin
        pend[q] = 0;
        tmr[q]  = 0;
      end
    end else begin
      for (int q = 0; q < 4; q++) begin
        fetch_ack[q] <= fetch_req[q] & ~fetch_ack[q];
        done = (pend[q] > 0) && (tmr[q] >= (slow ? 20 : 1));
        mem_done[q] <= done;
        tmr[q] = (done || pend[q] == 0) ? 0 : tmr[q] + 1;
        pend[q] = pend[q] + int'(fetch_ack[q]) + int'(dma_buf_grant && dma_buf_queue == q) - int'(done);
      end
    end
  end
endmodule
`default_nettype wire

// ==== rx_queue_enable_control_tb_top.sv ====
// Self-checking bench for the receive queue enable control.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module rx_queue_enable_control_tb_top;
  import rxq_pkg::*;
  logic          clk, nrst, reg_wr, reg_rd, pkt_valid, pkt_mcast, pkt_tagged, pkt_ack;
  logic          pkt_accept, pkt_drop, ctx_close, dma_buf_req, dma_buf_grant, slow, rd_d;
  logic          ecc_en, nfsw, nfsr;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata, rnd, exp_r;
  logic [13:0]   pkt_len;
  logic [11:0]   pkt_hash, pkt_vlan;
  logic [1:0]    pkt_queue, pkt_out_queue, dma_buf_queue;
  logic [3:0]    fetch_req, fetch_ack, mem_done, wb_allow;
  logic [4:0]    exp_p;
  logic [DW-1:0] rq[$];
  logic [4:0]    pq[$];
  int            error_cnt, checks, cyc;

  rx_queue_enable_control u_rx_queue_enable_control (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pkt_valid(pkt_valid),
    .pkt_queue(pkt_queue), .pkt_len(pkt_len), .pkt_mcast(pkt_mcast), .pkt_hash(pkt_hash),
    .pkt_tagged(pkt_tagged), .pkt_vlan(pkt_vlan), .pkt_ack(pkt_ack), .pkt_accept(pkt_accept),
    .pkt_drop(pkt_drop), .pkt_out_queue(pkt_out_queue), .ctx_close(ctx_close), .fetch_req(fetch_req),
    .fetch_ack(fetch_ack), .mem_done(mem_done), .wb_allow(wb_allow), .dma_buf_req(dma_buf_req),
    .dma_buf_queue(dma_buf_queue), .dma_buf_grant(dma_buf_grant), .filter_ecc_report_enable(ecc_en),
    .nfs_write_detect_disable(nfsw), .nfs_read_detect_disable(nfsr));
  ring_mem_model u_ring_mem_model (.clk(clk), .nrst(nrst), .slow(slow), .fetch_req(fetch_req),
    .dma_buf_grant(dma_buf_grant), .dma_buf_queue(dma_buf_queue), .fetch_ack(fetch_ack), .mem_done(mem_done));

  // ****************************
  // Bus tasks and result watcher
  // ****************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [AW-1:0] qa(input int q, input logic [3:0] s);
    return QBASE_OFS + AW'(q * 16) + AW'(s);
  endfunction
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
    rq.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  // Flags are mcast, tagged, ack; idx feeds both table lookups
  task automatic pk(input logic [1:0] q, input logic [13:0] len, input logic [2:0] f, input logic [11:0] idx,
                    input logic acc, input logic cx);
    pq.push_back({acc, ~acc, cx, q});
    @(posedge clk);
    pkt_valid <= 1'b1;
    pkt_queue <= q;
    pkt_len <= len;
    {pkt_mcast, pkt_tagged, pkt_ack} <= f;
    pkt_hash <= idx;
    pkt_vlan <= idx;
    @(posedge clk);
    pkt_valid <= 1'b0;
  endtask
  task automatic summarize();
    if (error_cnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) begin
    if (rd_d) begin
      exp_r = rq.pop_front();
      `CHK("reg_rdata", exp_r, reg_rdata)
    end
    if (pkt_accept | pkt_drop) begin
      exp_p = pq.pop_front();
      `CHK("verdict", exp_p, {pkt_accept, pkt_drop, ctx_close, pkt_out_queue})
    end
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end

  // ****************************
  // Scenarios
  // ****************************
  initial begin
    {nrst, reg_wr, reg_rd, pkt_valid, pkt_mcast, pkt_tagged, pkt_ack, dma_buf_req, slow} = '0;
    {reg_addr, reg_wdata, pkt_len, pkt_hash, pkt_vlan, pkt_queue, dma_buf_queue} = '0;
    rnd = 32'h6300;
    // address entries, header buffers and moderation live outside this block
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd(GCTRL_OFS, 32'h0);
    rd(FRAME_OFS, 32'(STD_FRAME));
    rd(qa(0, QCTRL_SUB), {2'b00, LIMIT_RST, 16'h0000});
    rd(12'h7F0, 32'h0);
    rd(MCAST_OFS + 12'h014, 32'h0);
    pk(2'd0, 14'd64, 3'b000, 12'h000, 1'b0, 1'b0);
    wr(qa(0, QCTRL_SUB), 32'h5);
    rd(STAT_OFS, 32'h0);
    repeat (ARM_CYCLES + 2) @(posedge clk);
    rd(STAT_OFS, 32'h1);
    wr(qa(0, QLEN_SUB), 32'd16);
    wr(qa(0, QTAIL_SUB), 32'd15);
    repeat (60) @(posedge clk);
    rd(qa(0, QHEAD_SUB), 32'd15);
    @(negedge clk);
    `CHK("fetch_wb", 8'h01, {fetch_req, wb_allow})
    wr(MCAST_OFS + 12'h014, 32'h20);
    wr(VLAN_OFS + 12'h024, 32'h8);
    wr(GCTRL_OFS, 32'h7F);
    @(negedge clk);
    `CHK("side_bits", 3'b111, {ecc_en, nfsw, nfsr})
    pk(2'd0, 14'd64, 3'b100, 12'h0A5, 1'b1, 1'b0);
    pk(2'd0, 14'd64, 3'b100, 12'h0A6, 1'b0, 1'b0);
    pk(2'd0, 14'd64, 3'b010, 12'h123, 1'b1, 1'b0);
    pk(2'd0, 14'd64, 3'b010, 12'h124, 1'b0, 1'b0);
    pk(2'd0, 14'd1518, 3'b000, 12'h000, 1'b1, 1'b0);
    pk(2'd0, 14'd1519, 3'b000, 12'h000, 1'b0, 1'b0);
    wr(FRAME_OFS, 32'd9000);
    wr(GCTRL_OFS, 32'hFF);
    pk(2'd0, 14'd9000, 3'b000, 12'h000, 1'b1, 1'b0);
    pk(2'd0, 14'd9001, 3'b000, 12'h000, 1'b0, 1'b0);
    wr(qa(0, QCTRL_SUB), 32'h0064_0007);
    pk(2'd0, 14'd100, 3'b000, 12'h000, 1'b1, 1'b0);
    pk(2'd0, 14'd101, 3'b000, 12'h000, 1'b0, 1'b0);
    wr(qa(0, QCTRL_SUB), 32'h0064_0005);
    pk(2'd0, 14'd64, 3'b000, 12'h000, 1'b1, 1'b0);
    pk(2'd0, 14'd64, 3'b001, 12'h000, 1'b1, 1'b1);
    pk(2'd0, 14'd64, 3'b001, 12'h000, 1'b1, 1'b0);
    wr(GCTRL_OFS, 32'hF7);
    pk(2'd0, 14'd64, 3'b000, 12'h000, 1'b1, 1'b0);
    for (int i = 0; i < 24; i++) begin
      rnd = lfsr(rnd);
      pk(rnd[1:0], {3'b000, rnd[12:2]}, 3'b000, rnd[24:13], rnd[1:0] == 2'd0, 1'b0);
    end
    slow <= 1'b1;
    @(posedge clk);
    dma_buf_req <= 1'b1;
    dma_buf_queue <= 2'd0;
    @(negedge clk);
    `CHK("grant_on", 1'b1, dma_buf_grant)
    wr(qa(0, QCTRL_SUB), 32'h0);
    @(negedge clk);
    `CHK("grant_off", 1'b0, dma_buf_grant)
    `CHK("fetch_wb_off", 8'h00, {fetch_req, wb_allow})
    @(posedge clk);
    dma_buf_req <= 1'b0;
    rd(STAT_OFS, 32'h1);
    pk(2'd0, 14'd64, 3'b000, 12'h000, 1'b0, 1'b0);
    repeat (150) @(posedge clk);
    rd(STAT_OFS, 32'h0);
    wr(GCTRL_OFS, 32'h0);
    repeat (5) @(posedge clk);
    `CHK("pending", 0, rq.size() + pq.size())
    summarize();
  end
endmodule
`default_nettype wire
